/* logic/dcpi_pkg.sv */
// constants and types shared by the control pin interface
package dcpi_pkg;
  // ----------
  // register offsets
  // ----------
  localparam logic [11:0] DCPI_OFF_CTRL = 12'h000;
  localparam logic [11:0] DCPI_OFF_FREQ1 = 12'h004;
  localparam logic [11:0] DCPI_OFF_FREQ2 = 12'h008;
  localparam logic [11:0] DCPI_OFF_PHASE1 = 12'h00C;
  localparam logic [11:0] DCPI_OFF_PHASE2 = 12'h010;
  localparam logic [11:0] DCPI_OFF_CHIRP_STEP = 12'h014;
  localparam logic [11:0] DCPI_OFF_RAMP_STEP = 12'h018;
  localparam logic [11:0] DCPI_OFF_STATUS = 12'h01C;
  localparam logic [11:0] DCPI_OFF_FREQ_OUT = 12'h020;
  localparam logic [11:0] DCPI_OFF_PROG_BASE = 12'h100;
  localparam logic [3:0] DCPI_PROG_PAGE = 4'h1;
  // ----------
  // field positions and reset values
  // ----------
  localparam int DCPI_CTRL_UPDATE_BIT = 8;
  localparam int DCPI_ST_HOLD_BIT = 0;
  localparam int DCPI_ST_KEY_BIT = 1;
  localparam int DCPI_ST_SHK_BIT = 2;
  localparam int DCPI_ST_SERIAL_BIT = 3;
  localparam int DCPI_ST_AMP_LSB = 16;
  localparam int DCPI_AMP_W = 12;
  localparam int DCPI_PHASE_W = 14;
  localparam int DCPI_PROG_DEPTH = 64;
  localparam logic [31:0] DCPI_FREQ_RST = 32'h0000_0000;
  localparam logic [DCPI_AMP_W-1:0] DCPI_AMP_FULL = 12'hFFF;
  localparam logic [DCPI_AMP_W-1:0] DCPI_AMP_ZERO = 12'h000;
  localparam logic [DCPI_AMP_W-1:0] DCPI_RAMP_RST = 12'h001;
  localparam logic [1:0] DCPI_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCPI_RESP_SLVERR = 2'h2;
  // ----------
  // timing and serial frame counts
  // ----------
  localparam logic [3:0] DCPI_UD_PULSE_CYCLES = 4'h8;
  localparam logic [4:0] DCPI_SER_INSTR_LAST = 5'h07;
  localparam logic [4:0] DCPI_SER_WDATA_LAST = 5'h0F;
  localparam logic [4:0] DCPI_SER_RDATA_FIRST = 5'h10;
  localparam logic [4:0] DCPI_SER_RDATA_END = 5'h18;
  localparam logic [4:0] DCPI_SER_RDATA_TOP = 5'h17;
  // ----------
  // types
  // ----------
  typedef enum logic [1:0] {KEY_SINGLE, KEY_FSK, KEY_BPSK, KEY_CHIRP} dcpi_key_mode_type;
  typedef struct packed {
    logic three_wire;
    logic shaped_en;
    dcpi_key_mode_type mode;
    logic ud_input;
  } dcpi_ctrl_type;
  localparam dcpi_ctrl_type DCPI_CTRL_RST = '{1'b0, 1'b0, KEY_SINGLE, 1'b0};
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } dcpi_prog_write_type;
endpackage

/* logic/dcpi_top.sv */
// control pin interface: programming port, update strobe, keying pins, axi4-lite registers
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dcpi_top (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // programming port, update strobe and keying pins
  input wire logic serial_select_pin,
  input wire logic [7:0] parallel_data_bus_i,
  output logic [7:0] parallel_data_bus_o,
  output logic parallel_data_bus_oe,
  input wire logic [5:0] register_address_pins,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  output logic serial_bidir_pin_o,
  output logic serial_bidir_pin_oe,
  input wire logic write_strobe_or_serial_clock,
  input wire logic read_strobe_or_chip_select_n,
  input wire logic register_update_strobe_i,
  output logic register_update_strobe_o,
  output logic register_update_strobe_oe,
  input wire logic keying_select_pin,
  input wire logic shaped_keying_pin,
  // synthesizer core controls
  output logic [31:0] freq_word,
  output logic [dcpi_pkg::DCPI_PHASE_W-1:0] phase_word,
  output logic [dcpi_pkg::DCPI_AMP_W-1:0] amplitude_word
);
  import dcpi_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [DCPI_AMP_W-1:0] ramp_amp(input logic [DCPI_AMP_W-1:0] amp,
                                                     input logic [DCPI_AMP_W-1:0] step, input logic up);
    logic [DCPI_AMP_W:0] sum;
    sum = '0;
    if (up) begin
      sum = {1'b0, amp} + {1'b0, step};
      return sum[DCPI_AMP_W] ? DCPI_AMP_FULL : sum[DCPI_AMP_W-1:0];
    end
    return (amp > step) ? amp - step : DCPI_AMP_ZERO;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // meta flops feed only the second stage
  logic [19:0] pin_meta_q, pin_sync_q;
  logic sel_serial, key_s, shk_s, ud_in_s, wr_s, rd_n_s;
  logic [7:0] data_s;
  logic [5:0] addr_s;
  always_ff @(posedge aclk) begin
    pin_meta_q <= {serial_select_pin, keying_select_pin, shaped_keying_pin, register_update_strobe_i,
                   write_strobe_or_serial_clock, read_strobe_or_chip_select_n, parallel_data_bus_i,
                   register_address_pins};
    pin_sync_q <= pin_meta_q;
  end
  assign {sel_serial, key_s, shk_s, ud_in_s, wr_s, rd_n_s, data_s, addr_s} = pin_sync_q;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  dcpi_ctrl_type ctrl_q;
  logic [31:0] freq1_q, freq2_q, chirp_step_q, chirp_acc_q;
  logic [DCPI_PHASE_W-1:0] phase1_q, phase2_q;
  logic [DCPI_AMP_W-1:0] ramp_step_q, amp_q;
  logic [7:0] buf_q [DCPI_PROG_DEPTH];
  logic [7:0] act_q [DCPI_PROG_DEPTH];
  logic wr_s_d1_q, ud_in_d1_q;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic aw_got_q, w_got_q, bvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  wire do_wr = aw_got_q && w_got_q && !bvalid_q;
  wire wr_ctrl = do_wr && (awaddr_q == DCPI_OFF_CTRL);
  wire wr_f1 = do_wr && (awaddr_q == DCPI_OFF_FREQ1);
  wire wr_f2 = do_wr && (awaddr_q == DCPI_OFF_FREQ2);
  wire wr_p1 = do_wr && (awaddr_q == DCPI_OFF_PHASE1);
  wire wr_p2 = do_wr && (awaddr_q == DCPI_OFF_PHASE2);
  wire wr_cs = do_wr && (awaddr_q == DCPI_OFF_CHIRP_STEP);
  wire wr_rs = do_wr && (awaddr_q == DCPI_OFF_RAMP_STEP);
  wire wr_ok = wr_ctrl || wr_f1 || wr_f2 || wr_p1 || wr_p2 || wr_cs || wr_rs;
  wire [31:0] ctrl_word = {27'h0, ctrl_q};
  wire [31:0] ctrl_new = merge_bytes(ctrl_word, wdata_q, wstrb_q);
  wire update_req = wr_ctrl && ctrl_new[DCPI_CTRL_UPDATE_BIT];
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= DCPI_RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? DCPI_RESP_OKAY : DCPI_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= DCPI_CTRL_RST;
      freq1_q <= DCPI_FREQ_RST;
      freq2_q <= DCPI_FREQ_RST;
      phase1_q <= '0;
      phase2_q <= '0;
      chirp_step_q <= DCPI_FREQ_RST;
      ramp_step_q <= DCPI_RAMP_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_new[4:0];
      if (wr_f1) freq1_q <= merge_bytes(freq1_q, wdata_q, wstrb_q);
      if (wr_f2) freq2_q <= merge_bytes(freq2_q, wdata_q, wstrb_q);
      if (wr_p1) phase1_q <= wdata_q[DCPI_PHASE_W-1:0];
      if (wr_p2) phase2_q <= wdata_q[DCPI_PHASE_W-1:0];
      if (wr_cs) chirp_step_q <= merge_bytes(chirp_step_q, wdata_q, wstrb_q);
      if (wr_rs) ramp_step_q <= wdata_q[DCPI_AMP_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_mux;
  logic rd_hit;
  wire rd_prog = s_axi_araddr[11:8] == DCPI_PROG_PAGE;
  wire [31:0] status_word = {4'h0, amp_q, 12'h000, sel_serial, shk_s, key_s,
                             (ctrl_q.mode == KEY_CHIRP) && key_s};
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      DCPI_OFF_CTRL: rd_mux = ctrl_word;
      DCPI_OFF_FREQ1: rd_mux = freq1_q;
      DCPI_OFF_FREQ2: rd_mux = freq2_q;
      DCPI_OFF_PHASE1: rd_mux = {18'h0, phase1_q};
      DCPI_OFF_PHASE2: rd_mux = {18'h0, phase2_q};
      DCPI_OFF_CHIRP_STEP: rd_mux = chirp_step_q;
      DCPI_OFF_RAMP_STEP: rd_mux = {20'h0, ramp_step_q};
      DCPI_OFF_STATUS: rd_mux = status_word;
      DCPI_OFF_FREQ_OUT: rd_mux = freq_word;
      default: begin
        rd_hit = rd_prog && (s_axi_araddr[1:0] == 2'h0);
        rd_mux = rd_hit ? {24'h0, act_q[s_axi_araddr[7:2]]} : 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= DCPI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? DCPI_RESP_OKAY : DCPI_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // serial port, serial clock domain
  // ----------------------------------------------------------------
  // the serial clock only runs inside a frame, so frame state is
  // cleared by chip select, resync or leaving serial mode
  wire ser_frame_rst = read_strobe_or_chip_select_n || !serial_select_pin
                       || register_address_pins[2];
  wire ser_din = register_address_pins[0];
  logic [4:0] ser_cnt_q;
  logic [7:0] ser_sh_q, ser_instr_q, rd_byte_q;
  logic ser_out_q, ser_wr_tgl_q, ser_rd_tgl_q;
  logic [5:0] ser_rd_addr_q;
  dcpi_prog_write_type ser_msg_q;
  wire [7:0] ser_next = {ser_sh_q[6:0], ser_din};
  wire ser_rd_phase = ser_instr_q[7] && (ser_cnt_q >= DCPI_SER_RDATA_FIRST);
  wire [4:0] ser_bit_sel = DCPI_SER_RDATA_TOP - ser_cnt_q;

  always_ff @(posedge write_strobe_or_serial_clock or posedge ser_frame_rst) begin
    if (ser_frame_rst) begin
      ser_cnt_q <= 5'h00;
      ser_sh_q <= 8'h00;
      ser_instr_q <= 8'h00;
    end else begin
      ser_sh_q <= ser_next;
      if (ser_cnt_q != DCPI_SER_RDATA_END) ser_cnt_q <= ser_cnt_q + 5'h01;
      if (ser_cnt_q == DCPI_SER_INSTR_LAST) ser_instr_q <= ser_next;
    end
  end

  // event toggles must survive frame ends, so only system reset clears them
  always_ff @(posedge write_strobe_or_serial_clock or negedge aresetn) begin
    if (!aresetn) begin
      ser_wr_tgl_q <= 1'b0;
      ser_rd_tgl_q <= 1'b0;
      ser_rd_addr_q <= 6'h00;
      ser_msg_q <= '0;
    end else if (!ser_frame_rst) begin
      if (ser_cnt_q == DCPI_SER_INSTR_LAST && ser_next[7]) begin
        ser_rd_addr_q <= ser_next[5:0];
        ser_rd_tgl_q <= !ser_rd_tgl_q;
      end
      if (ser_cnt_q == DCPI_SER_WDATA_LAST && !ser_instr_q[7]) begin
        ser_msg_q <= '{ser_instr_q[5:0], ser_next};
        ser_wr_tgl_q <= !ser_wr_tgl_q;
      end
    end
  end

  // read data shifts out on falling edges after one dummy byte
  always_ff @(negedge write_strobe_or_serial_clock or posedge ser_frame_rst) begin
    if (ser_frame_rst) begin
      ser_out_q <= 1'b0;
    end else begin
      ser_out_q <= ser_rd_phase && (ser_cnt_q < DCPI_SER_RDATA_END) && rd_byte_q[ser_bit_sel[2:0]];
    end
  end

  wire ser_drive = sel_serial && ser_rd_phase && !read_strobe_or_chip_select_n;
  assign serial_out_pin_o = ser_out_q;
  assign serial_out_pin_oe = ser_drive && ctrl_q.three_wire;
  assign serial_bidir_pin_o = ser_out_q;
  assign serial_bidir_pin_oe = ser_drive && !ctrl_q.three_wire;

  // ----------------------------------------------------------------
  // serial events into the system clock domain
  // ----------------------------------------------------------------
  logic [2:0] wr_tgl_q, rd_tgl_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_tgl_q <= 3'h0;
      rd_tgl_q <= 3'h0;
    end else begin
      wr_tgl_q <= {wr_tgl_q[1:0], ser_wr_tgl_q};
      rd_tgl_q <= {rd_tgl_q[1:0], ser_rd_tgl_q};
    end
  end
  wire ser_wr_evt = wr_tgl_q[2] ^ wr_tgl_q[1];
  wire ser_rd_evt = rd_tgl_q[2] ^ rd_tgl_q[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_byte_q <= 8'h00;
    end else if (ser_rd_evt) begin
      rd_byte_q <= act_q[ser_rd_addr_q];
    end
  end

  // ----------------------------------------------------------------
  // parallel port and buffer transfer
  // ----------------------------------------------------------------
  wire par_mode = !sel_serial;
  wire par_wr_evt = par_mode && wr_s && !wr_s_d1_q;
  wire ud_pin_evt = ctrl_q.ud_input && ud_in_s && !ud_in_d1_q;
  wire transfer = ud_pin_evt || update_req;
  logic [3:0] ud_cnt_q, ud_cnt_d;
  logic ud_o_q;
  logic [7:0] par_o_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_s_d1_q <= 1'b1;
      ud_in_d1_q <= 1'b0;
      for (int i = 0; i < DCPI_PROG_DEPTH; i++) begin
        buf_q[i] <= 8'h00;
        act_q[i] <= 8'h00;
      end
    end else begin
      wr_s_d1_q <= wr_s;
      ud_in_d1_q <= ud_in_s;
      if (ser_wr_evt) buf_q[ser_msg_q.addr] <= ser_msg_q.data;
      else if (par_wr_evt) buf_q[addr_s] <= data_s;
      if (transfer) begin
        for (int i = 0; i < DCPI_PROG_DEPTH; i++) act_q[i] <= buf_q[i];
      end
    end
  end

  // parallel readback; pins are synchronised so the strobe needs margin
  always_ff @(posedge aclk) begin
    if (!aresetn) par_o_q <= 8'h00;
    else par_o_q <= act_q[addr_s];
  end
  assign parallel_data_bus_o = par_o_q;
  assign parallel_data_bus_oe = par_mode && !rd_n_s;

  // ----------------------------------------------------------------
  // update strobe output pulse
  // ----------------------------------------------------------------
  always_comb begin
    ud_cnt_d = ud_cnt_q;
    if (update_req && !ctrl_q.ud_input) ud_cnt_d = DCPI_UD_PULSE_CYCLES;
    else if (ud_cnt_q != 4'h0) ud_cnt_d = ud_cnt_q - 4'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ud_cnt_q <= 4'h0;
      ud_o_q <= 1'b0;
    end else begin
      ud_cnt_q <= ud_cnt_d;
      ud_o_q <= ud_cnt_d != 4'h0;
    end
  end
  assign register_update_strobe_o = ud_o_q;
  assign register_update_strobe_oe = !ctrl_q.ud_input;

  // ----------------------------------------------------------------
  // keying and shaped keying
  // ----------------------------------------------------------------
  logic [31:0] freq_q;
  logic [DCPI_PHASE_W-1:0] phase_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chirp_acc_q <= DCPI_FREQ_RST;
      freq_q <= DCPI_FREQ_RST;
      phase_q <= '0;
      amp_q <= DCPI_AMP_FULL;
    end else begin
      if (ctrl_q.mode != KEY_CHIRP || transfer) chirp_acc_q <= freq1_q;
      else if (!key_s) chirp_acc_q <= chirp_acc_q + chirp_step_q;
      case (ctrl_q.mode)
        KEY_FSK: freq_q <= key_s ? freq2_q : freq1_q;
        KEY_CHIRP: freq_q <= chirp_acc_q;
        default: freq_q <= freq1_q;
      endcase
      phase_q <= (ctrl_q.mode == KEY_BPSK && key_s) ? phase2_q : phase1_q;
      // disabled shaping holds full scale so the pin has no effect
      if (!ctrl_q.shaped_en) amp_q <= DCPI_AMP_FULL;
      else amp_q <= ramp_amp(amp_q, ramp_step_q, shk_s);
    end
  end
  assign freq_word = freq_q;
  assign phase_word = phase_q;
  assign amplitude_word = amp_q;

endmodule
`default_nettype wire

/* testbench/dcpi_asserts.sv */
// concurrent checks on the control pin interface ports
`timescale 1ns/10ps
`default_nettype none
module dcpi_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic serial_out_pin_oe,
  input wire logic serial_bidir_pin_oe,
  input wire logic parallel_data_bus_oe,
  input wire logic read_strobe_or_chip_select_n,
  input wire logic register_update_strobe_o,
  input wire logic register_update_strobe_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------
  // pins
  // ----------
  property p_ud_len;
    $rose(register_update_strobe_o) |-> register_update_strobe_o [*8] ##1 !register_update_strobe_o;
  endproperty
  a_ud_len: assert property (p_ud_len) else $error("ud pulse length");
  property p_ud_dir;
    register_update_strobe_o |-> register_update_strobe_oe;
  endproperty
  a_ud_dir: assert property (p_ud_dir) else $error("ud pulse as input");
  property p_sdo_cs;
    serial_out_pin_oe |-> !read_strobe_or_chip_select_n;
  endproperty
  a_sdo_cs: assert property (p_sdo_cs) else $error("sdo without cs");
  property p_one_drv;
    !(serial_out_pin_oe && serial_bidir_pin_oe);
  endproperty
  a_one_drv: assert property (p_one_drv) else $error("two serial drivers");
  property p_par_ser;
    (serial_out_pin_oe || serial_bidir_pin_oe) |-> !parallel_data_bus_oe;
  endproperty
  a_par_ser: assert property (p_par_ser) else $error("bus in serial mode");
  property p_par_rd;
    read_strobe_or_chip_select_n [*4] |-> !parallel_data_bus_oe;
  endproperty
  a_par_rd: assert property (p_par_rd) else $error("bus without strobe");
  // ----------
  // register bus
  // ----------
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("r dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("r late");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("aw while b");
endmodule
bind dcpi_top dcpi_asserts u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .serial_out_pin_oe,
  .serial_bidir_pin_oe, .parallel_data_bus_oe, .read_strobe_or_chip_select_n, .register_update_strobe_o,
  .register_update_strobe_oe);
`default_nettype wire

/* testbench/dcpi_host_model.sv */
// host controller model driving the programming port pins
`timescale 1ns/10ps
`default_nettype none
module dcpi_host_model (
  output logic wr_sclk,
  output logic rd_cs_n,
  output logic [5:0] addr,
  output logic [7:0] dbus,
  input wire logic [7:0] dbus_o,
  input wire logic dbus_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sdio_o,
  input wire logic sdio_oe
);
  logic [5:0] a_q = 6'h00;
  logic [7:0] d_q = 8'h00;
  logic drv = 1'b1;
  // released line reads inverted
  assign addr = {a_q[5:1], sdio_oe ? sdio_o : (drv ? a_q[0] : ~a_q[0])};
  assign dbus = dbus_oe ? dbus_o : d_q;
  initial begin
    wr_sclk = 1'b1;
    rd_cs_n = 1'b1;
  end
  // sclk idles high: no false write edge
  task automatic sbit(input logic b);
    wr_sclk = 1'b0;
    a_q[0] = b;
    #62.5 wr_sclk = 1'b1;
    #62.5;
  endtask
  task automatic rbit(input logic tw, inout logic [7:0] v);
    wr_sclk = 1'b0;
    #62.5 v = {v[6:0], tw ? (sdo_oe ? sdo_o : ~v[0]) : addr[0]};
    wr_sclk = 1'b1;
    #62.5;
  endtask
  task automatic frame(input logic rd, input logic tw, input logic [5:0] ra, input logic [7:0] wd,
                       output logic [7:0] q);
    logic [15:0] w;
    w = {rd, 1'b0, ra, wd};
    q = 8'h00;
    a_q = 6'h00;
    rd_cs_n = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) sbit(w[i]);
    drv = tw;
    if (rd) for (int i = 0; i < 8; i++) rbit(tw, q);
    drv = 1'b1;
    #100 rd_cs_n = 1'b1;
    #200;
  endtask
  task automatic abort(input logic [11:0] w);
    rd_cs_n = 1'b0;
    #40;
    for (int i = 11; i >= 0; i--) sbit(w[i]);
    a_q[2] = 1'b1;
    #200 a_q[2] = 1'b0;
    #100;
  endtask
  task automatic pwr(input logic [5:0] ra, input logic [7:0] v);
    a_q = ra;
    d_q = v;
    #40 wr_sclk = 1'b0;
    #100 wr_sclk = 1'b1;
    #100;
  endtask
  task automatic prd(input logic [5:0] ra, output logic [7:0] v);
    a_q = ra;
    #40 rd_cs_n = 1'b0;
    #200 v = dbus;
    rd_cs_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the control pin interface
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dcpi_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ssel = 1'b0, ud_drv = 1'b0, key = 1'b0, shk = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, freq;
  logic [1:0] bresp, rresp;
  logic [7:0] dbus, dbus_o;
  logic [5:0] addr;
  logic [13:0] phase;
  logic [11:0] amp;
  logic awready, wready, bvalid, arready, rvalid, dbus_oe, sdo_o, sdo_oe, sdio_o, sdio_oe;
  logic sclk, cs_n, ud_i, ud_o, ud_oe;
  int mismatches = 0, checked = 0, cyc = 0, ud_cnt = 0, seed = 32'h272fda41;
  int bufm[64], actm[64];
  assign ud_i = ud_oe ? ud_o : ud_drv;
  dcpi_top u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_select_pin(ssel),
    .parallel_data_bus_i(dbus), .parallel_data_bus_o(dbus_o), .parallel_data_bus_oe(dbus_oe),
    .register_address_pins(addr), .serial_out_pin_o(sdo_o), .serial_out_pin_oe(sdo_oe),
    .serial_bidir_pin_o(sdio_o), .serial_bidir_pin_oe(sdio_oe), .write_strobe_or_serial_clock(sclk),
    .read_strobe_or_chip_select_n(cs_n), .register_update_strobe_i(ud_i), .register_update_strobe_o(ud_o),
    .register_update_strobe_oe(ud_oe), .keying_select_pin(key), .shaped_keying_pin(shk),
    .freq_word(freq), .phase_word(phase), .amplitude_word(amp));
  dcpi_host_model u_host (.wr_sclk(sclk), .rd_cs_n(cs_n), .addr, .dbus, .dbus_o, .dbus_oe, .sdo_o, .sdo_oe,
    .sdio_o, .sdio_oe);
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (ud_o === 1'b1) ud_cnt++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ----------
  // helpers
  // ----------
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = DCPI_RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = DCPI_RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
  endtask
  task automatic pchk(input int a);
    rdc(DCPI_OFF_PROG_BASE + 12'(a * 4), actm[a]);
  endtask
  // pulse only when the strobe is an output
  task automatic upd(input logic [31:0] c);
    ud_cnt = 0;
    wr(DCPI_OFF_CTRL, c | 32'h100);
    actm = bufm;
    w(12);
    chk("ud pulse", c[0] ? 0 : 8, ud_cnt);
  endtask
  task automatic sw(input logic tw, input int a, input int v);
    logic [7:0] q;
    u_host.frame(1'b0, tw, 6'(a), 8'(v), q);
    bufm[a] = v & 255;
  endtask
  task automatic sr(input logic tw, input int a);
    logic [7:0] q;
    u_host.frame(1'b1, tw, 6'(a), 8'h00, q);
    chk("serial rd", actm[a], q);
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    int a;
    logic [31:0] v, f0, f1, f2, p1, p2;
    logic [7:0] q;
    aresetn <= 1'b0;
    w(20);
    aresetn <= 1'b1;
    w(2);
    chk("ud oe", 1, ud_oe);
    chk("amp", DCPI_AMP_FULL, amp);
    rdc(12'h300, 0, DCPI_RESP_SLVERR);
    wr(DCPI_OFF_STATUS, 32'hFFFF, DCPI_RESP_SLVERR);
    for (int i = 0; i < 64; i++) begin
      bufm[i] = $random(seed) & 255;
      u_host.pwr(6'(i), 8'(bufm[i]));
    end
    upd(0);
    for (int i = 0; i < 64; i++) pchk(i);
    a = $random(seed) & 63;
    u_host.prd(6'(a), q);
    chk("par rd", actm[a], q);
    ssel <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      upd(m << 4);
      v = $random(seed) & 255;
      sw(m[0], a, v);
      pchk(a);
      upd(m << 4);
      pchk(a);
      sr(m[0], a);
    end
    u_host.abort({2'b00, 6'(a), 4'hA});
    sw(1'b1, a ^ 1, 8'(~v));
    upd(32'h10);
    pchk(a);
    pchk(a ^ 1);
    wr(DCPI_OFF_CTRL, 32'h11);
    chk("ud oe", 0, ud_oe);
    sw(1'b1, a, v ^ 32'h5A);
    ud_drv <= 1'b1;
    w(6);
    ud_drv <= 1'b0;
    actm = bufm;
    pchk(a);
    f1 = $random(seed);
    f2 = $random(seed);
    p1 = $random(seed);
    p2 = $random(seed);
    wr(DCPI_OFF_FREQ1, f1);
    wr(DCPI_OFF_FREQ2, f2);
    wr(DCPI_OFF_PHASE1, p1);
    wr(DCPI_OFF_PHASE2, p2);
    for (int m = 1; m < 3; m++) begin
      wr(DCPI_OFF_CTRL, m << 1);
      for (int k = 0; k < 2; k++) begin
        key <= k[0];
        w(6);
        if (m == 1) chk("freq", k ? f2 : f1, freq);
        else chk("phase", (k ? p2 : p1) & 32'h3FFF, phase);
      end
    end
    wr(DCPI_OFF_CHIRP_STEP, 32'h10);
    key <= 1'b1;
    wr(DCPI_OFF_CTRL, 32'h106);
    w(6);
    chk("hold", f1, freq);
    w(5);
    chk("hold", f1, freq);
    key <= 1'b0;
    w(6);
    f0 = freq;
    w(1);
    chk("sweep", f0 + 32'h10, freq);
    wr(DCPI_OFF_RAMP_STEP, 32'h100);
    w(20);
    chk("amp", DCPI_AMP_FULL, amp);
    wr(DCPI_OFF_CTRL, 32'h8);
    w(30);
    chk("amp", DCPI_AMP_ZERO, amp);
    shk <= 1'b1;
    w(30);
    chk("amp", DCPI_AMP_FULL, amp);
    tally_and_finish();
  end
endmodule
`default_nettype wire
